/* core/tsop_pkg.sv */
// Purpose: shared constants of the transport stream output port
// Assumes: 50 MHz system clock
// Notes:   byte clock figures are in ns and converted to cycles here
package tsop_pkg;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int SYS_CLK_PERIOD_NS = 20;
   localparam int TS_CLK_PERIOD_NS = 160;
   // half period in system cycles, rounded down, never below one
   localparam int TS_HALF_CYC_RAW = TS_CLK_PERIOD_NS / (2 * SYS_CLK_PERIOD_NS);
   localparam int TS_HALF_CYC = (TS_HALF_CYC_RAW < 1) ? 1 : TS_HALF_CYC_RAW;

   // ---------------------------------------------------------------
   // data path
   // ---------------------------------------------------------------
   localparam int BYTE_W = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_W = BYTE_W + 1;     // packet start flag above the byte
   localparam int INT_REGS = 4;
   localparam int BER_W = 16;
   localparam int TONE_ACC_W = 24;

   // ---------------------------------------------------------------
   // demod_diagnostic_control register
   // ---------------------------------------------------------------
   localparam logic [7:0] DIAG_CTL_OFFSET = 8'h67;
   localparam int DIAG_ERR_SEL_BIT = 7;    // 1: no signal, 0: uncorrectable block

   // ---------------------------------------------------------------
   // status output functions
   // ---------------------------------------------------------------
   localparam logic [1:0] STAT_LOCK = 2'h0;
   localparam logic [1:0] STAT_BER_TONE = 2'h1;
   localparam logic [1:0] STAT_ERROR = 2'h2;
   localparam logic [1:0] STAT_LOW = 2'h3;
endpackage

/* core/tsop_fifo_if.sv */
// Purpose: valid/ready carrier between the framer and its byte buffer
// Assumes: both sides on the system clock
// Notes:   fill side writes, drain side reads
`timescale 1ns/100ps
`default_nettype none
interface tsop_fifo_if #(
   parameter int W = 9
);
   logic wr_valid;
   logic wr_ready;
   logic [W-1:0] wr_data;
   logic rd_valid;
   logic rd_ready;
   logic [W-1:0] rd_data;

   modport store (
      input wr_valid, wr_data, rd_ready,
      output wr_ready, rd_valid, rd_data
   );
   modport user (
      output wr_valid, wr_data, rd_ready,
      input wr_ready, rd_valid, rd_data
   );
endinterface
`default_nettype wire

/* core/tsop_fifo.sv */
// Purpose: byte buffer between the decoder stream and the byte-rate output
// Assumes: synchronous, one clock
// Notes:   full and empty are exact; read data is registered in the array
`timescale 1ns/100ps
`default_nettype none
module tsop_fifo #(
   parameter int W = 9,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // buffer ports
   tsop_fifo_if.store f
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
   localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
   logic [AW:0] count_q, count_d;
   logic do_wr, do_rd;

   // -----------------------------------------------------------------
   // flags and pointer arithmetic
   // -----------------------------------------------------------------
   always_comb begin
      f.wr_ready = (count_q != DEPTH_C);
      f.rd_valid = (count_q != '0);
      f.rd_data = mem_q[rd_ptr_q];
      do_wr = f.wr_valid && f.wr_ready;
      do_rd = f.rd_valid && f.rd_ready;
      wr_ptr_d = wr_ptr_q;
      rd_ptr_d = rd_ptr_q;
      count_d = count_q;
      if (do_wr) begin
         wr_ptr_d = (wr_ptr_q == LAST_C) ? '0 : wr_ptr_q + 1'b1;
      end
      if (do_rd) begin
         rd_ptr_d = (rd_ptr_q == LAST_C) ? '0 : rd_ptr_q + 1'b1;
      end
      if (do_wr && !do_rd) begin
         count_d = count_q + 1'b1;
      end else if (do_rd && !do_wr) begin
         count_d = count_q - 1'b1;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         count_q <= count_d;
      end
   end

   // storage has no reset, it is only read when the count says so
   always_ff @(posedge clk_i) begin
      if (do_wr) begin
         mem_q[wr_ptr_q] <= f.wr_data;
      end
   end
endmodule // tsop_fifo
`default_nettype wire

/* core/tsop_top.sv */
// Purpose: byte-parallel transport stream output port with error, interrupt
//          and status pins
// Assumes: decoder stream and control levels on SYS_CLK_I; sleep is a pin
// Notes:   byte clock is divided from the system clock and driven out
//
// Functional notes
// - start flag high for the whole first byte of a packet, low for the rest
// - valid flag high only in byte clock cycles carrying a real byte
// - eight-bit byte bus, placed in high impedance when control asks
// - byte clock runs at byte rate, one cycle per byte slot
// - error pin low for uncorrectable block or no signal, chosen by bit 7
// - error pin polarity can be inverted by configuration
// - interrupt pin low while pending, released once all active registers read
// - reset input is active low
// - sleep stops oscillator and releases byte bus and control pins; error, status, interrupt and converters keep working
// - status pin function chosen by register, one is a tone tracking BER
`timescale 1ns/100ps
`default_nettype none
module tsop_top #(
   parameter int HALF_CYC = tsop_pkg::TS_HALF_CYC,
   parameter int DEPTH = tsop_pkg::FIFO_DEPTH,
   parameter int NINT = tsop_pkg::INT_REGS
) (
   // clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RST_N_I,
   // decoded packet stream from the decoder
   input wire logic [tsop_pkg::BYTE_W-1:0] STRM_DATA_I,
   input wire logic STRM_START_I,
   input wire logic STRM_VALID_I,
   output logic STRM_READY_O,
   // control levels
   input wire logic [7:0] DIAG_CTL_I,
   input wire logic ERR_INVERT_I,
   input wire logic BUS_HIZ_I,
   input wire logic [1:0] STATUS_SEL_I,
   input wire logic ADC_OFF_I,
   // decoder conditions
   input wire logic BLOCK_UNCORR_I,
   input wire logic NO_SIGNAL_I,
   input wire logic LOCKED_I,
   input wire logic [tsop_pkg::BER_W-1:0] BER_I,
   input wire logic [NINT-1:0] INT_EVENT_I,
   input wire logic [NINT-1:0] INT_REG_READ_I,
   // sleep pin
   input wire logic SLEEP_I,
   // transport output pins
   output logic [tsop_pkg::BYTE_W-1:0] TS_BYTE_O,
   output logic TS_BUS_OE_O,
   output logic TS_START_O,
   output logic TS_VALID_O,
   output logic TS_CLK_O,
   output logic TS_CTRL_OE_O,
   output logic BLK_ERR_O,
   // interrupt open drain
   output logic IRQ_N_O,
   output logic IRQ_OE_O,
   // status and power
   output logic STATUS_O,
   output logic OSC_RUN_O,
   output logic ADC_OFF_O
);
   localparam int CW = $clog2(HALF_CYC + 1);
   localparam logic [CW-1:0] HALF_LAST = CW'(HALF_CYC - 1);

   tsop_fifo_if #(.W(tsop_pkg::FIFO_W)) fb ();

   tsop_fifo #(
      .W(tsop_pkg::FIFO_W),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk_i(SYS_CLK_I),
      .rst_n_i(RST_N_I),
      .f(fb.store)
   );

   // -----------------------------------------------------------------
   // sleep pin synchroniser
   // -----------------------------------------------------------------
   logic sleep_m_q, sleep_q;

   // first stage feeds only the second
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         sleep_m_q <= 1'b0;
         sleep_q <= 1'b0;
      end else begin
         sleep_m_q <= SLEEP_I;
         sleep_q <= sleep_m_q;
      end
   end

   // -----------------------------------------------------------------
   // stream input into the buffer
   // -----------------------------------------------------------------
   // back-pressure reaches the decoder through the buffer ready
   always_comb begin
      fb.wr_valid = STRM_VALID_I;
      fb.wr_data = {STRM_START_I, STRM_DATA_I};
      STRM_READY_O = fb.wr_ready;
   end

   // -----------------------------------------------------------------
   // byte clock and output registers
   // -----------------------------------------------------------------
   logic [CW-1:0] div_q, div_d;
   logic clk_q, clk_d;
   logic fall;
   logic [tsop_pkg::BYTE_W-1:0] byte_q, byte_d;
   logic start_q, start_d;
   logic valid_q, valid_d;

   // the clock is forced low at once in sleep, so a slot in progress is cut short and its valid cleared
   always_comb begin
      div_d = div_q;
      clk_d = clk_q;
      fall = 1'b0;
      if (sleep_q) begin
         div_d = '0;
         clk_d = 1'b0;
      end else if (div_q == HALF_LAST) begin
         div_d = '0;
         clk_d = !clk_q;
         fall = clk_q;
      end else begin
         div_d = div_q + 1'b1;
      end
   end

   // one pop per byte slot, taken on the falling edge
   always_comb begin
      fb.rd_ready = fall;
      byte_d = byte_q;
      start_d = start_q;
      valid_d = valid_q;
      if (sleep_q) begin
         start_d = 1'b0;
         valid_d = 1'b0;
      end else if (fall) begin
         valid_d = fb.rd_valid;
         start_d = fb.rd_valid && fb.rd_data[tsop_pkg::BYTE_W];
         if (fb.rd_valid) begin
            byte_d = fb.rd_data[tsop_pkg::BYTE_W-1:0];
         end
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         div_q <= '0;
         clk_q <= 1'b0;
         byte_q <= '0;
         start_q <= 1'b0;
         valid_q <= 1'b0;
      end else begin
         div_q <= div_d;
         clk_q <= clk_d;
         byte_q <= byte_d;
         start_q <= start_d;
         valid_q <= valid_d;
      end
   end

   // -----------------------------------------------------------------
   // error indicator, status, power and enables
   // -----------------------------------------------------------------
   logic err_q, err_d;
   logic stat_q, stat_d;
   logic [tsop_pkg::TONE_ACC_W-1:0] acc_q, acc_d;
   logic bus_oe_q, bus_oe_d;
   logic ctrl_oe_q, ctrl_oe_d;
   logic osc_q, osc_d;
   logic adc_q, adc_d;
   logic err_act;

   always_comb begin
      // mode bit picks which condition pulls the pin
      err_act = DIAG_CTL_I[tsop_pkg::DIAG_ERR_SEL_BIT] ? NO_SIGNAL_I
                                                        : BLOCK_UNCORR_I;
      err_d = ERR_INVERT_I ? err_act : !err_act;
      // tone pitch scales with the error rate: f = ber * fclk / 2^24
      acc_d = acc_q + tsop_pkg::TONE_ACC_W'(BER_I);
      if (STATUS_SEL_I == tsop_pkg::STAT_LOCK) begin
         stat_d = LOCKED_I;
      end else if (STATUS_SEL_I == tsop_pkg::STAT_BER_TONE) begin
         stat_d = acc_q[tsop_pkg::TONE_ACC_W-1];
      end else if (STATUS_SEL_I == tsop_pkg::STAT_ERROR) begin
         stat_d = err_act;
      end else begin
         stat_d = 1'b0;
      end
      bus_oe_d = !BUS_HIZ_I && !sleep_q;
      ctrl_oe_d = !sleep_q;
      osc_d = !sleep_q;
      adc_d = ADC_OFF_I; // converters keep their own control in sleep
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         err_q <= 1'b1;
         stat_q <= 1'b0;
         acc_q <= '0;
         bus_oe_q <= 1'b0;
         ctrl_oe_q <= 1'b0;
         osc_q <= 1'b1;
         adc_q <= 1'b0;
      end else begin
         err_q <= err_d;
         stat_q <= stat_d;
         acc_q <= acc_d;
         bus_oe_q <= bus_oe_d;
         ctrl_oe_q <= ctrl_oe_d;
         osc_q <= osc_d;
         adc_q <= adc_d;
      end
   end

   // -----------------------------------------------------------------
   // interrupt request
   // -----------------------------------------------------------------
   logic [NINT-1:0] pend_q, pend_d;

   // a new event in the same cycle as the read keeps the register pending
   always_comb begin
      pend_d = (pend_q & ~INT_REG_READ_I) | INT_EVENT_I;
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         pend_q <= '0;
      end else begin
         pend_q <= pend_d;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   always_comb begin
      TS_BYTE_O = byte_q;
      TS_START_O = start_q;
      TS_VALID_O = valid_q;
      TS_CLK_O = clk_q;
      TS_BUS_OE_O = bus_oe_q;
      TS_CTRL_OE_O = ctrl_oe_q;
      BLK_ERR_O = err_q;
      IRQ_N_O = 1'b0; // open drain only ever pulls low
      IRQ_OE_O = |pend_q;
      STATUS_O = stat_q;
      OSC_RUN_O = osc_q;
      ADC_OFF_O = adc_q;
   end
endmodule // tsop_top
`default_nettype wire

/* testbench/tsop_chk.sv */
// Purpose: port checks of the transport stream output port
// Assumes: one clock domain, default byte clock divider
// Notes:   bound onto tsop_top after the module
`timescale 1ns/100ps
`default_nettype none
module tsop_chk #(
   parameter int HALF_CYC = 4,
   parameter int NINT = 4
) (
   // clock, reset and inputs
   input wire logic SYS_CLK_I,
   input wire logic RST_N_I,
   input wire logic BUS_HIZ_I,
   input wire logic ADC_OFF_I,
   input wire logic [NINT-1:0] INT_EVENT_I,
   input wire logic SLEEP_I,
   // outputs
   input wire logic STRM_READY_O,
   input wire logic [7:0] TS_BYTE_O,
   input wire logic TS_BUS_OE_O,
   input wire logic TS_START_O,
   input wire logic TS_VALID_O,
   input wire logic TS_CLK_O,
   input wire logic IRQ_N_O,
   input wire logic IRQ_OE_O,
   input wire logic OSC_RUN_O,
   input wire logic ADC_OFF_O
);
   // ---------------------------------------------------------------
   // byte clock level length
   // ---------------------------------------------------------------
   logic clk_q, armed_q;
   logic [3:0] run_q;
   // first level after reset or sleep is not judged: its start is free
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         clk_q <= 1'b0;
         armed_q <= 1'b0;
         run_q <= 4'h0;
      end else begin
         clk_q <= TS_CLK_O;
         armed_q <= OSC_RUN_O && (armed_q || TS_CLK_O != clk_q);
         run_q <= (TS_CLK_O != clk_q || !OSC_RUN_O) ? 4'h1 : run_q + 4'h1;
      end
   end
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);
   a_start_valid: assert property (TS_START_O |-> TS_VALID_O)
      else $error("start without valid");
   a_byte_fall: assert property (OSC_RUN_O && $past(OSC_RUN_O) && !(clk_q && !TS_CLK_O)
      |-> $stable({TS_BYTE_O, TS_START_O, TS_VALID_O})) else $error("bus moved off clock fall");
   a_clk_half: assert property (disable iff (!RST_N_I || !OSC_RUN_O)
      armed_q && TS_CLK_O != clk_q |-> run_q == 4'(HALF_CYC)) else $error("byte clock period");
   a_hiz_off: assert property (BUS_HIZ_I |=> !TS_BUS_OE_O)
      else $error("bus driven in hiz");
   a_irq_set: assert property (|INT_EVENT_I |-> ##[1:2] IRQ_OE_O)
      else $error("irq not pulled");
   a_irq_data: assert property (!IRQ_N_O)
      else $error("irq data high");
   // flops clear asynchronously as reset falls; the second reset edge is judged, clear of a fall in the first edge's time step
   a_reset_quiet: assert property (disable iff (1'b0)
      !RST_N_I ##1 !RST_N_I |-> !TS_VALID_O && !IRQ_OE_O) else $error("active in reset");
   a_sleep_stop: assert property (SLEEP_I [*5] |-> !OSC_RUN_O && !TS_CLK_O && !TS_VALID_O)
      else $error("running in sleep");
   a_adc_copy: assert property (1'b1 |=> ADC_OFF_O == $past(ADC_OFF_I))
      else $error("converter off wrong");
   c_start: cover property (TS_START_O);
   c_full: cover property (!STRM_READY_O);
   c_irq: cover property (IRQ_OE_O);
endmodule // tsop_chk
bind tsop_top tsop_chk #(.HALF_CYC(HALF_CYC), .NINT(NINT)) chk_u (
   .SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .BUS_HIZ_I(BUS_HIZ_I), .ADC_OFF_I(ADC_OFF_I),
   .INT_EVENT_I(INT_EVENT_I), .SLEEP_I(SLEEP_I), .STRM_READY_O(STRM_READY_O),
   .TS_BYTE_O(TS_BYTE_O), .TS_BUS_OE_O(TS_BUS_OE_O), .TS_START_O(TS_START_O),
   .TS_VALID_O(TS_VALID_O), .TS_CLK_O(TS_CLK_O), .IRQ_N_O(IRQ_N_O), .IRQ_OE_O(IRQ_OE_O),
   .OSC_RUN_O(OSC_RUN_O), .ADC_OFF_O(ADC_OFF_O)
);
`default_nettype wire

/* testbench/tsop_demux_model.sv */
// Purpose: receiving demultiplexer on the transport pins
// Assumes: byte clock seen through the system clock
// Notes:   one strobe per received byte
`timescale 1ns/100ps
`default_nettype none
module tsop_demux_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // transport pins
   input wire logic ts_clk_i,
   input wire logic [7:0] byte_i,
   input wire logic bus_oe_i,
   input wire logic start_i,
   input wire logic valid_i,
   input wire logic ctrl_oe_i,
   // received word
   output logic got_o,
   output logic [8:0] word_o
);
   logic clk_q;
   logic [7:0] last_q;
   // a released bus floats: show the inverse of what was last driven
   wire logic [7:0] bus_lvl = bus_oe_i ? byte_i : ~last_q;
   // sample on the byte clock rise, half a slot after the launch
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         clk_q <= 1'b0;
         last_q <= 8'h00;
         got_o <= 1'b0;
         word_o <= 9'h000;
      end else begin
         clk_q <= ts_clk_i;
         // remember only what was really driven, so a float keeps one level
         if (bus_oe_i) begin
            last_q <= byte_i;
         end
         got_o <= ts_clk_i && !clk_q && valid_i && ctrl_oe_i;
         word_o <= {start_i, bus_lvl};
      end
   end
endmodule // tsop_demux_model
`default_nettype wire

/* testbench/tsop_tb_top.sv */
// Purpose: self-checking bench of the transport stream output port
// Assumes: 50 MHz clock, default divider and depth
// Notes:   inputs move 2 ns after the rising edge
`timescale 1ns/100ps
`default_nettype none
module tsop_tb_top;
   logic clk = 1'b0, rst_n = 1'b0, s_start = 1'b0, s_valid = 1'b0, inv = 1'b0, hiz = 1'b0;
   logic adc_off = 1'b0, uncorr = 1'b0, nosig = 1'b0, locked = 1'b0, sleep = 1'b0;
   logic [7:0] s_data = 8'h00, diag = 8'h00;
   logic [1:0] stat_sel = 2'h0;
   logic [15:0] ber = 16'h0000;
   logic [3:0] int_ev = 4'h0, int_rd = 4'h0;
   logic s_ready, bus_oe, ts_start, ts_valid, ts_clk, ctrl_oe, blk_err, irq_n, irq_oe;
   logic status, osc_run, adc_off_o, got, lvl;
   logic [7:0] ts_byte;
   logic [8:0] word;
   logic [8:0] exp_q[$];
   int fails = 0, checks_done = 0, cycles = 0, n = 0;
   tsop_top dut_u (
      .SYS_CLK_I(clk), .RST_N_I(rst_n), .STRM_DATA_I(s_data), .STRM_START_I(s_start),
      .STRM_VALID_I(s_valid), .STRM_READY_O(s_ready), .DIAG_CTL_I(diag), .ERR_INVERT_I(inv),
      .BUS_HIZ_I(hiz), .STATUS_SEL_I(stat_sel), .ADC_OFF_I(adc_off), .BLOCK_UNCORR_I(uncorr),
      .NO_SIGNAL_I(nosig), .LOCKED_I(locked), .BER_I(ber), .INT_EVENT_I(int_ev),
      .INT_REG_READ_I(int_rd), .SLEEP_I(sleep), .TS_BYTE_O(ts_byte), .TS_BUS_OE_O(bus_oe),
      .TS_START_O(ts_start), .TS_VALID_O(ts_valid), .TS_CLK_O(ts_clk), .TS_CTRL_OE_O(ctrl_oe),
      .BLK_ERR_O(blk_err), .IRQ_N_O(irq_n), .IRQ_OE_O(irq_oe), .STATUS_O(status),
      .OSC_RUN_O(osc_run), .ADC_OFF_O(adc_off_o)
   );
   tsop_demux_model far_u (
      .clk_i(clk), .rst_n_i(rst_n), .ts_clk_i(ts_clk), .byte_i(ts_byte), .bus_oe_i(bus_oe),
      .start_i(ts_start), .valid_i(ts_valid), .ctrl_oe_i(ctrl_oe), .got_o(got), .word_o(word)
   );
   always #10 clk = ~clk;
   // every comparison is counted, a mismatch reported at once
   task automatic cmp_word(input logic [8:0] g, input logic [8:0] e);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cmp_pin(input logic g, input logic e);
      cmp_word({8'h00, g}, {8'h00, e});
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #2;
   endtask
   // ready only moves on edges, so its value now is what the next edge sees
   task automatic push(input logic [7:0] b, input logic s);
      logic rdy;
      s_data = b;
      s_start = s;
      s_valid = 1'b1;
      do begin
         rdy = s_ready;
         step(1);
      end while (!rdy);
      exp_q.push_back({s, b});
   endtask
   task automatic packet(input int len);
      for (int i = 0; i < len; i++) push(8'($urandom), i == 0);
      // one idle edge, so the next packet never raises valid in this time step
      s_valid = 1'b0;
      step(1);
   endtask
   // far side words against the oldest note; the ceiling ends a hang
   always @(posedge clk) begin
      cycles++;
      if (got) begin
         cmp_word(word, exp_q.size() > 0 ? exp_q.pop_front() : ~word);
      end
      if (cycles == 10000) begin
         fails++;
         conclude();
      end
   end
   initial begin
      void'($urandom(44620));
      step(5);
      rst_n = 1'b1;
      for (int k = 0; k < 4; k++) packet($urandom_range(6, 1));
      // up to 24 bytes at 8 cycles a slot still drain after the last take
      step(250);
      cmp_word(9'(exp_q.size()), 9'h000);
      // asleep the output stalls, so the buffer fills until it refuses
      sleep = 1'b1;
      adc_off = 1'b1;
      step(4);
      cmp_word({5'h00, ctrl_oe, osc_run, ts_clk, adc_off_o}, 9'h001);
      while (s_ready) begin
         push(8'($urandom), n == 0);
         n++;
      end
      step(3);
      cmp_word(9'(n), 9'(tsop_pkg::FIFO_DEPTH));
      s_valid = 1'b0;
      sleep = 1'b0;
      step(200);
      cmp_word(9'(exp_q.size()), 9'h000);
      hiz = 1'b1;
      step(2);
      cmp_pin(bus_oe, 1'b0);
      hiz = 1'b0;
      stat_sel = tsop_pkg::STAT_ERROR;
      // every selector, polarity and condition pairing
      for (int i = 0; i < 16; i++) begin
         diag = {i[0], 7'($urandom)};
         inv = i[1];
         uncorr = i[2];
         nosig = i[3];
         step(2);
         cmp_pin(blk_err, inv ~^ (diag[7] ? nosig : uncorr));
         cmp_pin(status, diag[7] ? nosig : uncorr);
      end
      cmp_pin(bus_oe, 1'b1);
      stat_sel = tsop_pkg::STAT_BER_TONE;
      // tone is fast at a high error rate and all but still at a low one
      for (int k = 0; k < 2; k++) begin
         ber = (k == 0) ? 16'hffff : 16'h0100;
         n = 0;
         repeat (1000) begin
            lvl = status;
            step(1);
            if (status !== lvl) n++;
         end
         cmp_pin(n > 4, k == 0);
      end
      // lock level and the quiet selector reach the pin one cycle later
      stat_sel = tsop_pkg::STAT_LOCK;
      for (int i = 0; i < 4; i++) begin
         locked = 1'($urandom);
         step(2);
         cmp_pin(status, locked);
      end
      stat_sel = tsop_pkg::STAT_LOW;
      locked = 1'b1;
      step(2);
      cmp_pin(status, 1'b0);
      // two sources pending: the pin stays pulled until both are read
      int_ev = 4'h5;
      step(1);
      int_ev = 4'h0;
      int_rd = 4'h1;
      step(1);
      int_rd = 4'h0;
      step(2);
      cmp_word({7'h00, irq_oe, irq_n}, 9'h002);
      int_rd = 4'h4;
      step(1);
      int_rd = 4'h0;
      step(2);
      cmp_pin(irq_oe, 1'b0);
      rst_n = 1'b0;
      step(2);
      cmp_word({7'h00, ts_valid, blk_err}, 9'h001);
      rst_n = 1'b1;
      packet(4);
      step(60);
      cmp_word(9'(exp_q.size()), 9'h000);
      conclude();
   end
endmodule // tsop_tb_top
`default_nettype wire
